// ### logic/adc_link_consts.svh
// Shared constants of the serial control byte link
`ifndef ADC_LINK_CONSTS_SVH
`define ADC_LINK_CONSTS_SVH
// Control byte field positions
`define CTRL_BITS 8
`define CTRL_START_BIT 7
`define CTRL_CH_HI 6
`define CTRL_CH_MID 5
`define CTRL_CH_LO 4
`define CTRL_SGL_BIT 2
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
// Power and clock mode codes
`define MODE_AUTO_PD 2'h0
`define MODE_RESERVED 2'h1
`define MODE_INT_CLK 2'h2
`define MODE_EXT_CLK 2'h3
// Bit counts inside a frame, and the result FIFO depth
`define RESULT_BITS 16
`define ACQ_CNT 3'h3
`define CTRL_LAST_CNT 3'h7
`define LSB_CNT 4'hF
`define FIRST_SAMPLE_IDX 6'h09
`define LAST_SAMPLE_IDX 6'h18
`define MIN_EXT_CLKS 25
`define MAX_FRAME_CLKS 32
`define FRAME_CLKS 32
`define FIFO_DEPTH 16
// Timing
`define MCLK_MHZ 100
`define INT_CONV_NS 8000
`define INT_CONV_CYC ((`INT_CONV_NS * `MCLK_MHZ) / 1000)
`define SCLK_HALF_NS 200
`define SCLK_HALF_CYC ((`SCLK_HALF_NS * `MCLK_MHZ + 999) / 1000)
`endif

// ### logic/adc_link_pkg.sv
// Types shared by both ends of the serial control byte link
`include "adc_link_consts.svh"
package adc_link_pkg;
  typedef logic [2:0] chan_t;
  typedef logic [1:0] mode_t;
  typedef logic [`RESULT_BITS-1:0] code_t;
  typedef struct packed {
    chan_t pos;
    chan_t neg;
    logic com;
  } mux_sel_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CTRL = 5'h02,
    ST_BUSY = 5'h04,
    ST_CONV = 5'h08,
    ST_DATA = 5'h10
  } dev_state_t;
  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_SETUP = 6'h02,
    H_CLOCK = 6'h04,
    H_WAIT = 6'h08,
    H_DONE = 6'h10,
    H_GAP = 6'h20
  } host_state_t;
endpackage : adc_link_pkg

// ### logic/adc_link_if.sv
// Pin bundle between the converter end and the host end
`timescale 1ns/1ps
interface adc_link_if;
  logic serial_clock;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic busy;
  logic busy_oe;
  modport dev (
    input serial_clock,
    input cs_n,
    input din,
    output dout,
    output dout_oe,
    output busy,
    output busy_oe
  );
  modport host (
    output serial_clock,
    output cs_n,
    output din,
    input dout,
    input dout_oe,
    input busy,
    input busy_oe
  );
endinterface : adc_link_if

// ### logic/adc_device_end.sv
// Converter end: control byte receiver, mode state and result shifter
`timescale 1ns/1ps
`include "adc_link_consts.svh"
// What this block does
// - Host always sends leading one first
// - Ignore serial input until start bit
// - Byte: start, channel, mode, power bits
// - Single-ended: channel positive, common negative
// - Differential: bits pick pair, bit6 polarity
// - Single/differential bit selects mux mode
// - Auto power-down between conversions, instant wake
// - Mode one-zero selects internal conversion clock
// - Mode one-one: always powered, external clock
// - Host never sends reserved mode zero-one
// - Host serial clock shifts all data
// - Clock mode change lags one conversion
// - Host sets clock mode before power-down
// - Power-down keeps previous clock mode
// - External mode: one-period busy after byte
// - Sixteen result bits, MSB first, falling edges
// - Host gives at least 25 clocks
// - Next byte may overlap LSB output
// - Zeros after result bits
// - Deselect floats dout, and busy in external mode only; there busy is low on reselect
// - Acquire after channel bits, hold at byte end
// - Result is two's complement code
// - Internal mode: busy low during conversion
module adc_device_end #(
  parameter int unsigned CONV_CYC = `INT_CONV_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  adc_link_if.dev link,
  input wire adc_link_pkg::code_t sample_code,
  input wire logic shutdown_n,
  output adc_link_pkg::chan_t pos_channel,
  output adc_link_pkg::chan_t neg_channel,
  output logic neg_is_com,
  output logic acquire,
  output logic hold,
  output logic powered,
  output logic int_clock
);
  import adc_link_pkg::*;

  localparam int CW = $clog2(CONV_CYC + 1);

  if (CONV_CYC < 1) begin : g_bad_conv
    $error("CONV_CYC must be at least one cycle");
  end

  // Synchroniser order: serial_clock, cs_n, din, shutdown_n
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sclk_prev_q;
  dev_state_t state_q;
  logic [6:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] out_cnt_q;
  code_t data_q;
  logic [CW-1:0] conv_cnt_q;
  logic dout_q;
  logic busy_q;
  mode_t pend_mode_q;
  logic int_clk_q;
  logic auto_pd_q;
  logic acquire_q;
  logic hold_q;
  logic powered_q;
  mux_sel_t mux_q;
  logic sel;
  logic on;
  logic at_rise;
  logic at_fall;
  logic acq_go;
  logic byte_done;
  logic conv_end;
  logic abort;
  logic [7:0] full_byte;

  // Pins from the host arrive asynchronously, so two flops each
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // Reset shows the pins idle: deselected, clock and data low
      sync1_q <= 4'h4;
      sync2_q <= 4'h4;
      sclk_prev_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= {link.serial_clock, link.cs_n, link.din, shutdown_n};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[3];
    end
  end

  // Edge and event decode on the synchronised pins
  always_comb begin
    sel = !sync2_q[2];
    on = sync2_q[0];
    at_rise = sync2_q[3] && !sclk_prev_q && sel;
    at_fall = !sync2_q[3] && sclk_prev_q && sel;
    full_byte = {1'b1, shift_q[5:0], sync2_q[1]};
    acq_go = (state_q == ST_CTRL) && at_rise && (bit_cnt_q == `ACQ_CNT);
    byte_done = (state_q == ST_CTRL) && at_rise && (bit_cnt_q == `CTRL_LAST_CNT);
    conv_end = ((state_q == ST_CONV) && (conv_cnt_q == '0))
      || ((state_q == ST_DATA) && at_fall && (out_cnt_q == `LSB_CNT) && !int_clk_q);
    // Internal conversions survive deselect; external ones are stepped by the link
    abort = !on || (!sel && ((state_q == ST_CTRL) || (state_q == ST_BUSY)
      || ((state_q == ST_DATA) && !int_clk_q)));
  end

  // Frame sequencer: byte in, busy, result out
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      shift_q <= 7'h00;
      bit_cnt_q <= 3'h0;
      out_cnt_q <= 4'h0;
      data_q <= '0;
      conv_cnt_q <= '0;
      dout_q <= 1'b0;
      busy_q <= 1'b0;
      pend_mode_q <= `MODE_EXT_CLK;
    end else if (ce) begin
      if (abort) begin
        state_q <= ST_IDLE;
        busy_q <= 1'b0;
        dout_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (at_rise && sync2_q[1]) begin
              state_q <= ST_CTRL;
              bit_cnt_q <= 3'h1;
            end
            if (at_fall) begin
              dout_q <= 1'b0;
            end
          end
          ST_CTRL: begin
            if (at_rise) begin
              shift_q <= {shift_q[5:0], sync2_q[1]};
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (byte_done) begin
              // Mode bits wait for the end of this conversion
              pend_mode_q <= full_byte[`CTRL_MODE_HI:`CTRL_MODE_LO];
              data_q <= sample_code;
              out_cnt_q <= 4'h0;
              if (int_clk_q) begin
                state_q <= ST_CONV;
                busy_q <= 1'b0;
                conv_cnt_q <= CW'(CONV_CYC - 1);
              end else begin
                state_q <= ST_BUSY;
              end
            end
          end
          ST_BUSY: begin
            if (at_fall) begin
              busy_q <= 1'b1;
              state_q <= ST_DATA;
            end
          end
          ST_CONV: begin
            if (conv_cnt_q == '0) begin
              busy_q <= 1'b1;
              state_q <= ST_DATA;
            end else begin
              conv_cnt_q <= conv_cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
          end
          ST_DATA: begin
            if (at_fall) begin
              busy_q <= int_clk_q;
              dout_q <= data_q[`RESULT_BITS-1];
              data_q <= {data_q[`RESULT_BITS-2:0], 1'b0};
              out_cnt_q <= out_cnt_q + 4'h1;
              // Back to start hunting so the next byte may overlap the LSB
              if (out_cnt_q == `LSB_CNT) begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Clock and power mode, applied only once the running conversion ends
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_clk_q <= 1'b0;
      auto_pd_q <= 1'b0;
    end else if (ce && conv_end) begin
      case (pend_mode_q)
        `MODE_AUTO_PD: begin
          auto_pd_q <= 1'b1;
        end
        `MODE_INT_CLK: begin
          int_clk_q <= 1'b1;
          auto_pd_q <= 1'b0;
        end
        `MODE_EXT_CLK: begin
          int_clk_q <= 1'b0;
          auto_pd_q <= 1'b0;
        end
        default: begin
          auto_pd_q <= auto_pd_q; // Reserved code changes nothing
        end
      endcase
    end
  end

  // Sample and hold phases
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acquire_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (ce) begin
      if (abort || conv_end) begin
        acquire_q <= 1'b0;
        hold_q <= 1'b0;
      end else if (byte_done) begin
        acquire_q <= 1'b0;
        hold_q <= 1'b1;
      end else if (acq_go) begin
        acquire_q <= 1'b1;
      end
    end
  end

  // Multiplexer setting, bit 3 never looked at
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mux_q <= '0;
    end else if (ce && byte_done) begin
      mux_q.com <= full_byte[`CTRL_SGL_BIT];
      mux_q.pos <= {full_byte[`CTRL_CH_MID], full_byte[`CTRL_CH_LO], full_byte[`CTRL_CH_HI]};
      if (full_byte[`CTRL_SGL_BIT]) begin
        mux_q.neg <= 3'h0;
      end else begin
        mux_q.neg <= {full_byte[`CTRL_CH_MID], full_byte[`CTRL_CH_LO], !full_byte[`CTRL_CH_HI]};
      end
    end
  end

  // Analog power: auto power-down wakes for every sample, no extra delay
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      powered_q <= 1'b0;
    end else if (ce) begin
      powered_q <= on && (!auto_pd_q || acq_go || acquire_q || hold_q);
    end
  end

  // Outputs; busy keeps driving in internal mode even when deselected
  assign link.dout = dout_q;
  assign link.dout_oe = sel;
  assign link.busy = busy_q;
  assign link.busy_oe = sel || int_clk_q;
  assign pos_channel = mux_q.pos;
  assign neg_channel = mux_q.neg;
  assign neg_is_com = mux_q.com;
  assign acquire = acquire_q;
  assign hold = hold_q;
  assign powered = powered_q;
  assign int_clock = int_clk_q;
endmodule : adc_device_end

// ### logic/adc_host_end.sv
// Host end: frame generator, serial clock divider and result FIFO
`timescale 1ns/1ps
`include "adc_link_consts.svh"
// Result FIFO in flops with valid/ready on both sides
module result_fifo #(
  parameter int unsigned WIDTH = `RESULT_BITS,
  parameter int unsigned DEPTH = `FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Both sides refuse while frozen, so no handshake is lost with ce low
  assign in_ready = ce && (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = ce && (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage writes only; pointers wrap naturally at the power of two
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : result_fifo

module adc_host_end #(
  parameter int unsigned FRAME_CLKS = `FRAME_CLKS,
  parameter int unsigned HALF_CYC = `SCLK_HALF_CYC,
  parameter int unsigned FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  adc_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire adc_link_pkg::chan_t cmd_channel,
  input wire logic cmd_single,
  input wire adc_link_pkg::mode_t cmd_mode,
  output logic result_valid,
  input wire logic result_ready,
  output adc_link_pkg::code_t result_data,
  output logic frame_busy
);
  import adc_link_pkg::*;

  if (FRAME_CLKS < `MIN_EXT_CLKS || FRAME_CLKS > `MAX_FRAME_CLKS || HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad
    $error("FRAME_CLKS must be 25..32 and HALF_CYC 1..255");
  end

  host_state_t state_q;
  logic [1:0] dout_s1_q;
  logic [1:0] busy_s1_q;
  logic dout_s;
  logic busy_s;
  logic sclk_q;
  logic cs_n_q;
  logic din_q;
  logic [7:0] half_q;
  logic [5:0] idx_q;
  logic [7:0] tx_q;
  code_t rx_q;
  logic push_q;
  logic frame_int_q;
  logic seen_low_q;
  logic eff_int_q;
  logic mode_set_q;
  mode_t sent_mode_q;
  logic fifo_ready;
  logic accept;
  mode_t safe_mode;
  logic [7:0] ctrl_byte;
  logic [5:0] last_idx;

  // Channel number to select bits, same weights for both mux modes
  always_comb begin
    if (cmd_mode == `MODE_RESERVED) begin
      safe_mode = eff_int_q ? `MODE_INT_CLK : `MODE_EXT_CLK;
    end else if (cmd_mode == `MODE_AUTO_PD && !mode_set_q) begin
      safe_mode = `MODE_EXT_CLK;
    end else begin
      safe_mode = cmd_mode;
    end
    ctrl_byte = {1'b1, cmd_channel[0], cmd_channel[2], cmd_channel[1], 1'b0, cmd_single, safe_mode};
    last_idx = frame_int_q ? 6'(`MIN_EXT_CLKS) : 6'(FRAME_CLKS);
  end

  assign accept = cmd_valid && cmd_ready;
  // New frames stall while the FIFO has no room for their result
  assign cmd_ready = ce && (state_q == H_IDLE) && fifo_ready;
  assign frame_busy = (state_q != H_IDLE);
  assign dout_s = dout_s1_q[1];
  assign busy_s = busy_s1_q[1];

  // Returned pins are asynchronous to mclk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dout_s1_q <= 2'h0;
      busy_s1_q <= 2'h0;
    end else if (ce) begin
      dout_s1_q <= {dout_s1_q[0], link.dout};
      busy_s1_q <= {busy_s1_q[0], link.busy};
    end
  end

  // Frame engine; clock idles low, din changes on falling edges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= H_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      din_q <= 1'b0;
      half_q <= 8'h00;
      idx_q <= 6'h00;
      tx_q <= 8'h00;
      rx_q <= '0;
      push_q <= 1'b0;
      frame_int_q <= 1'b0;
      seen_low_q <= 1'b0;
    end else if (ce) begin
      push_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (accept) begin
            tx_q <= {ctrl_byte[6:0], 1'b0};
            din_q <= ctrl_byte[7];
            cs_n_q <= 1'b0;
            frame_int_q <= eff_int_q;
            idx_q <= 6'h00;
            half_q <= 8'(HALF_CYC - 1);
            state_q <= H_SETUP;
          end
        end
        H_SETUP, H_GAP: begin
          if (half_q != 8'h00) begin
            half_q <= half_q - 8'h01;
          end else begin
            half_q <= 8'(HALF_CYC - 1);
            state_q <= (state_q == H_SETUP) ? H_CLOCK : H_IDLE;
          end
        end
        H_CLOCK: begin
          if (half_q != 8'h00) begin
            half_q <= half_q - 8'h01;
          end else begin
            half_q <= 8'(HALF_CYC - 1);
            if (!sclk_q) begin
              sclk_q <= 1'b1;
              idx_q <= idx_q + 6'h01;
              if (idx_q >= `FIRST_SAMPLE_IDX && idx_q <= `LAST_SAMPLE_IDX) begin
                rx_q <= {rx_q[`RESULT_BITS-2:0], dout_s};
              end
            end else begin
              sclk_q <= 1'b0;
              din_q <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              if (idx_q == 6'(`CTRL_BITS) && frame_int_q) begin
                seen_low_q <= 1'b0;
                state_q <= H_WAIT;
              end else if (idx_q == last_idx) begin
                state_q <= H_DONE;
              end
            end
          end
        end
        H_WAIT: begin
          if (!busy_s) begin
            seen_low_q <= 1'b1;
          end else if (seen_low_q) begin
            state_q <= H_CLOCK;
          end
        end
        H_DONE: begin
          cs_n_q <= 1'b1;
          push_q <= 1'b1;
          state_q <= H_GAP;
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // Host copy of the device clock mode, which changes one frame late
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      eff_int_q <= 1'b0;
      mode_set_q <= 1'b0;
      sent_mode_q <= `MODE_EXT_CLK;
    end else if (ce) begin
      if (accept) begin
        sent_mode_q <= safe_mode;
        if (safe_mode[1]) begin
          mode_set_q <= 1'b1;
        end
      end
      if (state_q == H_DONE && sent_mode_q[1]) begin
        eff_int_q <= !sent_mode_q[0];
      end
    end
  end

  assign link.serial_clock = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din = din_q;

  result_fifo #(
    .WIDTH(`RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(rx_q),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );
endmodule : adc_host_end

// ### test/adc_link_asserts.sv
// Checker for the serial pins shared by the two link ends
`timescale 1ns/1ps
module adc_link_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic serial_clock,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic busy,
  input wire logic busy_oe
);
  logic sclk_q;
  logic mode_hi_q;
  logic [5:0] cnt_q;
  logic [3:0] since_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Rising edges per frame; cleared while deselected so every frame counts from zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cnt_q <= 6'h00;
      mode_hi_q <= 1'b0;
    end else begin
      sclk_q <= serial_clock;
      if (cs_n)
        cnt_q <= 6'h00;
      else if (serial_clock && !sclk_q && cnt_q != 6'h3F)
        cnt_q <= cnt_q + 6'h01;
      if (serial_clock && !sclk_q && cnt_q == 6'h06)
        mode_hi_q <= din;
    end
  end
  // Cycles since the last serial clock fall, saturating
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      since_q <= 4'hF;
    else if (!serial_clock && sclk_q)
      since_q <= 4'h0;
    else if (since_q != 4'hF)
      since_q <= since_q + 4'h1;
  end
  property p_oe_off;
    $rose(cs_n) |-> ##[1:6] !dout_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("dout enable stays on");
  property p_oe_on;
    $fell(cs_n) |-> ##[1:6] (dout_oe && busy_oe);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not enabled");
  property p_busy_edge;
    !cs_n && busy != $past(busy) |-> cnt_q inside {6'h00, 6'h08, 6'h09};
  endproperty
  a_busy_edge: assert property (p_busy_edge) else $error("busy moved off its slot");
  property p_busy_pulse;
    $rose(busy) && !cs_n && !serial_clock |-> busy [*8];
  endproperty
  a_busy_pulse: assert property (p_busy_pulse) else $error("busy pulse too short");
  property p_dout_window;
    !cs_n && dout |-> cnt_q inside {[6'h09:6'h19]};
  endproperty
  a_dout_window: assert property (p_dout_window) else $error("dout high outside result");
  property p_dout_step;
    !cs_n && $changed(dout) |-> since_q <= 4'h8;
  endproperty
  a_dout_step: assert property (p_dout_step) else $error("dout moved off a fall");
  property p_start;
    $rose(serial_clock) && cnt_q == 6'h00 |-> din;
  endproperty
  a_start: assert property (p_start) else $error("frame without start bit");
  property p_mode;
    $rose(serial_clock) && cnt_q == 6'h07 |-> mode_hi_q || !din;
  endproperty
  a_mode: assert property (p_mode) else $error("reserved mode sent");
  property p_count;
    $rose(cs_n) |-> cnt_q >= 6'h19;
  endproperty
  a_count: assert property (p_count) else $error("frame too short");
  property p_idle;
    cs_n && $past(cs_n) |-> !serial_clock;
  endproperty
  a_idle: assert property (p_idle) else $error("serial clock runs idle");
  c_ext: cover property ($rose(busy) && !cs_n && cnt_q == 6'h08);
  c_int: cover property ($fell(busy) && !cs_n && cnt_q == 6'h08);
  c_end: cover property ($rose(cs_n));
endmodule : adc_link_asserts

// ### test/testbench.sv
// Bench joining host end and converter end, plus a raw driver on a second converter
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  import adc_link_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b1;
  logic ce = 1'b1;
  logic shutdown_n_n = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  chan_t cmd_channel = 3'h0;
  logic cmd_single = 1'b0;
  mode_t cmd_mode = 2'h3;
  logic result_valid;
  logic result_ready = 1'b0;
  code_t result_data;
  logic frame_busy;
  code_t sample_code = 16'h0000;
  chan_t pos_channel, neg_channel, pos2, neg2;
  logic neg_is_com, powered, int_clock, com2;
  logic acq, hld, pow2, int2;
  int failures = 0;
  int n_compared = 0;
  int seed = 3997;
  code_t exp_q[$];
  mode_t modes [5] = '{2'h2, 2'h2, 2'h0, 2'h3, 2'h1};
  logic exp_int [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic exp_pow [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  adc_link_if link ();
  adc_link_if link2 ();
  adc_host_end #(.HALF_CYC(8)) adc_host_end_i (
    .mclk(mclk), .nrst(nrst), .ce(ce), .link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_channel(cmd_channel), .cmd_single(cmd_single), .cmd_mode(cmd_mode), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data), .frame_busy(frame_busy));
  adc_device_end #(.CONV_CYC(20)) adc_device_end_i (
    .mclk(mclk), .nrst(nrst), .ce(ce), .link(link.dev), .sample_code(sample_code), .shutdown_n(shutdown_n_n),
    .pos_channel(pos_channel), .neg_channel(neg_channel), .neg_is_com(neg_is_com), .acquire(acq), .hold(hld),
    .powered(powered), .int_clock(int_clock));
  // Second converter faced by a raw driver that sends junk before the start bit
  adc_device_end #(.CONV_CYC(20)) adc_device_end_i2 (
    .mclk(mclk), .nrst(nrst), .ce(ce), .link(link2.dev), .sample_code(sample_code), .shutdown_n(shutdown_n_n),
    .pos_channel(pos2), .neg_channel(neg2), .neg_is_com(com2), .acquire(), .hold(), .powered(pow2),
    .int_clock(int2));
  adc_link_asserts adc_link_asserts_i (
    .mclk(mclk), .nrst(nrst), .serial_clock(link.serial_clock), .cs_n(link.cs_n), .din(link.din),
    .dout(link.dout), .dout_oe(link.dout_oe), .busy(link.busy), .busy_oe(link.busy_oe));
  // Clock at 100 MHz
  initial forever #5 mclk = ~mclk;
  // Inputs change 1 ns after the edge so the design never races the bench
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // One command through the host; mux outputs are checked once the frame ends
  task automatic run_cmd(input chan_t ch, input logic single, input mode_t mode, input code_t code);
    int n;
    n = 0;
    sample_code = code;
    cmd_channel = ch;
    cmd_single = single;
    cmd_mode = mode;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 2000) begin step(); n++; end
    step();
    cmd_valid = 1'b0;
    while (frame_busy !== 1'b1 && n < 2100) begin step(); n++; end
    while (frame_busy === 1'b1 && n < 4000) begin step(); n++; end
    `CHK(n < 4000, 1'b1, "frame hung")
    `CHK(pos_channel, ch, "positive channel")
    `CHK(neg_channel, single ? 3'h0 : ch ^ 3'h1, "negative channel")
    `CHK(neg_is_com, single, "common reference")
    `CHK({acq, hld}, 2'b00, "sample phases left on")
  endtask : run_cmd
  // Pop one result after a random stall of the reader
  task automatic pop_check();
    int n;
    n = 0;
    repeat ($random(seed) & 3) step();
    while (result_valid !== 1'b1 && n < 100) begin step(); n++; end
    `CHK(result_data, exp_q.pop_front(), "result code")
    result_ready = 1'b1;
    step();
    result_ready = 1'b0;
  endtask : pop_check
  // Raw frame: two zeros, the control byte, then zeros to finish the conversion
  task automatic raw_frame(input logic [7:0] ctrl, input chan_t ep, input chan_t en, input logic ec);
    logic [39:0] bits;
    bits = {2'h0, ctrl, 30'h0};
    link2.cs_n = 1'b0;
    #100;
    for (int i = 39; i >= 0; i--) begin
      link2.din = bits[i];
      #62.5 link2.serial_clock = 1'b1;
      #62.5 link2.serial_clock = 1'b0;
    end
    link2.cs_n = 1'b1;
    repeat (10) step();
    `CHK({pos2, neg2, com2}, {ep, en, ec}, "raw mux setting")
  endtask : raw_frame
  initial begin
    code_t code;
    link2.cs_n = 1'b1;
    link2.serial_clock = 1'b0;
    link2.din = 1'b0;
    // A real falling edge, so the asynchronous resets are seen
    #1 nrst = 1'b0;
    repeat (10) @(posedge mclk);
    #1 nrst = 1'b1;
    // Fill the buffer with the reader stalled, then drain it
    for (int i = 0; i < 16; i++) begin
      code = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : code_t'($random(seed));
      exp_q.push_back(code);
      run_cmd(3'($random(seed)), 1'($random(seed)), 2'h3, code);
    end
    step();
    `CHK(cmd_ready, 1'b0, "full buffer took a command")
    repeat (16) pop_check();
    step();
    `CHK(result_valid, 1'b0, "buffer not empty")
    $display("test buffer done");
    // Every mode code in turn; the new mode shows only after its own frame
    for (int i = 0; i < 5; i++) begin
      code = code_t'($random(seed));
      exp_q.push_back(code);
      run_cmd(3'h5, 1'b1, modes[i], code);
      pop_check();
      `CHK(int_clock, exp_int[i], "clock mode")
      `CHK(powered, exp_pow[i], "power state")
    end
    // Clock enable low: a waiting command must not be taken
    ce = 1'b0;
    cmd_valid = 1'b1;
    repeat (4) step();
    `CHK({cmd_ready, frame_busy}, 2'b00, "frozen host took a command")
    cmd_valid = 1'b0;
    ce = 1'b1;
    $display("test modes done");
    raw_frame(8'hDF, 3'h3, 3'h0, 1'b1);
    raw_frame(8'hEB, 3'h5, 3'h4, 1'b0);
    raw_frame(8'h81, 3'h0, 3'h1, 1'b0);
    `CHK({int2, pow2}, 2'b01, "reserved mode changed state")
    $display("test raw frames done");
    // Shutdown pin drops power on both converters, release restores it
    shutdown_n_n = 1'b0;
    repeat (6) step();
    `CHK({powered, pow2}, 2'b00, "shutdown left power on")
    shutdown_n_n = 1'b1;
    repeat (6) step();
    `CHK({powered, pow2}, 2'b11, "power not back after shutdown")
    $display("test shutdown done");
    results();
  end
  // Watchdog sized well above the expected run of about 12500 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    results();
  end
endmodule : testbench
